// *** verilog/cms_pkg.sv ***
/*
 * Shared constants and carriers for the contact monitor supervisor.
 * Assumes a 40 MHz system clock; the SPI shifter lives outside this block.
 */

`default_nettype none

package cms_pkg;

   localparam int CLK_HZ          = 40_000_000;
   localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
   // Regulator startup, typical
   localparam int RAIL_START_US   = 1000;
   localparam int RAIL_START_CYC  = CLK_PER_US * RAIL_START_US;
   // Reset pulse width for the default timing capacitor
   localparam int RST_PULSE_US    = 2000;
   localparam int RST_PULSE_CYC   = CLK_PER_US * RST_PULSE_US;
   localparam int WD_FIRST_MULT   = 4;
   localparam int WD_SECOND_MULT  = 8;
   // Scan mode sampling window and period
   localparam int SCAN_PERIOD_US  = 50000;
   localparam int SCAN_PERIOD_CYC = CLK_PER_US * SCAN_PERIOD_US;
   localparam int SCAN_ON_US      = 50;
   localparam int SCAN_ON_CYC     = CLK_PER_US * SCAN_ON_US;
   localparam int CNT_W           = 24;

   localparam logic [2:0]  SCAN_NORMAL     = 3'h0;
   localparam logic [2:0]  SCAN_FIXED_HYSTERESIS_SET_PIN = 3'h6;
   localparam logic [15:0] CMD_RESET       = 16'h0000;
   localparam logic [6:0]  STATUS_LOW_ZERO = 7'h00;

   typedef enum logic [2:0] {
      CMS_MODE_NORMAL = 3'b001,
      CMS_MODE_SCAN   = 3'b010,
      CMS_MODE_SHUT   = 3'b100
   } cms_mode_e;

   typedef enum logic [1:0] {
      CMS_REG_OFF = 2'b01,
      CMS_REG_ON  = 2'b10
   } cms_reg_e;

   // Command word, msb first: spare, scan cfg, path disable, polarity, masks
   typedef struct packed {
      logic [1:0] spare;
      logic [2:0] scan_config_field;
      logic       direct_path_disable;
      logic       pair67_polarity_sel;
      logic       pair45_polarity_sel;
      logic [7:0] alert_mask_bits;
   } cms_cmd_s;

   typedef struct packed {
      cms_cmd_s               cmd;
      cms_mode_e              mode;
      cms_reg_e               reg_st;
      logic [7:0]             contact_state_bits;
      logic                   alert;
      logic                   alert_n;
      logic [CNT_W-1:0]       wd_cnt;
      logic                   kick_q;
      logic [CNT_W-1:0]       rst_cnt;
      logic                   rst_n;
      logic                   uv_q;
      logic [CNT_W-1:0]       rail_cnt;
      logic                   rail_ready;
      logic [CNT_W-1:0]       scan_cnt;
      logic [7:0]             sense_en;
      logic [3:0]             bat_pol;
      logic                   hysteresis_set_pin_adj;
      logic                   pt0;
      logic                   pt1;
      logic                   pt_oe_n;
   } cms_state_s;

endpackage

`default_nettype wire

// *** verilog/cms_supervisor.sv ***
/*
 * Contact monitor supervisor: modes, regulator wake/hold, staged watchdog,
 * undervoltage reset, alert masking, polarity grouping, pass-through.
 * Assumes debounced contact levels, a comparator bit for the rail sample,
 * and strobes from an external SPI shifter (chip-select fall, word load).
 */

`timescale 1ns/100ps
`default_nettype none

module cms_supervisor #(
   parameter int RST_PULSE_CYCLES  = cms_pkg::RST_PULSE_CYC,
   parameter int RAIL_START_CYCLES = cms_pkg::RAIL_START_CYC,
   parameter int SCAN_PERIOD_CYCLES = cms_pkg::SCAN_PERIOD_CYC,
   parameter int SCAN_ON_CYCLES    = cms_pkg::SCAN_ON_CYC
) (
   input  wire logic        sys_clk_in,                 // 40 MHz clock
   input  wire logic        srst_in,                    // Sync reset, high
   input  wire logic        shutdown_n_in,              // Low selects shutdown
   input  wire logic [7:0]  contact_inputs_in,          // Debounced contact levels
   input  wire logic        watchdog_kick_in,           // Kick, either edge
   input  wire logic        regulator_wake_n_in,        // Wake line, low wakes
   input  wire logic        regulator_hold_n_in,        // Hold line, high keeps on
   input  wire logic        undervoltage_sense_in,      // High: sample below ref
   input  wire logic        spi_cs_fall_in,             // Pulse on select fall
   input  wire logic        cmd_load_in,                // Pulse on select rise
   input  wire logic [15:0] cmd_word_in,                // Shifted command word
   output logic [15:0]      status_word_out,            // Status word to shifter
   output logic [7:0]       contact_state_bits_out,     // Contact status bits
   output logic [15:0]      command_word_out,           // Current command word
   output logic             alert_n_out,                // Alert pin level
   output logic             alert_oe_n_out,             // Low while pulling alert
   output logic             reset_n_out,                // Reset pin level
   output logic             reset_oe_n_out,             // Low while pulling reset
   output logic             regulator_on_out,           // Regulator enable
   output logic             rail_ready_out,             // Rail up after startup
   output logic             passthrough_out0,           // Level-shifted input 0
   output logic             passthrough_out1,           // Level-shifted input 1
   output logic             passthrough_oe_n_out,       // Low while pass-through drives
   output logic [7:0]       sense_enable_out,           // Sense resistor per input
   output logic [3:0]       battery_polarity_out,       // Inputs 4-7 battery sensing
   output logic             hysteresis_adjust_en_out,   // Adjustable hysteresis on
   output logic [2:0]       mode_out                    // One-hot operating mode
);

   localparam int W = cms_pkg::CNT_W;
   localparam logic [W-1:0] RST_LEN   = W'(RST_PULSE_CYCLES);
   localparam logic [W-1:0] WD_FIRST  = W'(cms_pkg::WD_FIRST_MULT * RST_PULSE_CYCLES);
   localparam logic [W-1:0] WD_SECOND = W'(cms_pkg::WD_SECOND_MULT * RST_PULSE_CYCLES);
   localparam logic [W-1:0] RAIL_LEN  = W'(RAIL_START_CYCLES);
   localparam logic [W-1:0] SCAN_PER  = W'(SCAN_PERIOD_CYCLES);
   localparam logic [W-1:0] SCAN_ON   = W'(SCAN_ON_CYCLES);
   localparam logic [W-1:0] ONE       = W'(1);

   cms_pkg::cms_state_s q;
   cms_pkg::cms_state_s d;

   logic       pt_act;
   logic       kick_edge;
   logic       sensing;
   logic [7:0] upd;
   logic [7:0] changed;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      d         = q;
      pt_act    = (q.mode == cms_pkg::CMS_MODE_NORMAL) && !q.cmd.direct_path_disable;
      kick_edge = watchdog_kick_in != q.kick_q;
      sensing   = (q.mode == cms_pkg::CMS_MODE_NORMAL)
                  || ((q.mode == cms_pkg::CMS_MODE_SCAN) && (q.scan_cnt < SCAN_ON));
      upd       = sensing ? 8'hFF : 8'h00;
      upd[1:0]  = pt_act ? 2'b00 : upd[1:0];
      changed   = upd & (contact_inputs_in ^ q.contact_state_bits);

      if (cmd_load_in)
      begin
         d.cmd = cms_pkg::cms_cmd_s'(cmd_word_in);
      end

      if (!shutdown_n_in)
      begin
         d.mode = cms_pkg::CMS_MODE_SHUT;
      end
      else if (q.cmd.scan_config_field != cms_pkg::SCAN_NORMAL)
      begin
         d.mode = cms_pkg::CMS_MODE_SCAN;
      end
      else
      begin
         d.mode = cms_pkg::CMS_MODE_NORMAL;
      end

      // Scan window timer
      d.scan_cnt = (q.scan_cnt >= SCAN_PER - ONE) ? '0 : q.scan_cnt + ONE;

      d.contact_state_bits = (contact_inputs_in & upd)
                             | (q.contact_state_bits & ~upd);

      // Sense resistors, polarity and hysteresis
      d.sense_en      = upd;
      d.bat_pol       = {{2{q.cmd.pair67_polarity_sel}},
                         {2{q.cmd.pair45_polarity_sel}}};
      d.hysteresis_set_pin_adj      = (q.mode == cms_pkg::CMS_MODE_NORMAL)
                        && (q.cmd.scan_config_field != cms_pkg::SCAN_FIXED_HYSTERESIS_SET_PIN);

      // Pass-through of inputs 0 and 1
      d.pt0     = pt_act ? contact_inputs_in[0] : 1'b1;
      d.pt1     = pt_act ? contact_inputs_in[1] : 1'b1;
      d.pt_oe_n = !pt_act;

      // Watchdog
      d.kick_q = watchdog_kick_in;
      if (kick_edge)
      begin
         d.wd_cnt = '0;
      end
      else if (q.wd_cnt >= WD_SECOND - ONE)
      begin
         d.wd_cnt = '0;
      end
      else
      begin
         d.wd_cnt = q.wd_cnt + ONE;
      end

      // Alert: select fall clears, events win over the clear
      if (spi_cs_fall_in)
      begin
         d.alert = 1'b0;
      end
      if (|(changed & ~q.cmd.alert_mask_bits))
      begin
         d.alert = 1'b1;
      end
      if (!kick_edge && (q.wd_cnt == WD_FIRST - ONE))
      begin
         d.alert = 1'b1;
      end
      if (!kick_edge && (q.wd_cnt >= WD_SECOND - ONE))
      begin
         d.alert = 1'b0;
      end
      d.alert_n = !d.alert;

      // Reset pulse
      d.uv_q = undervoltage_sense_in;
      if ((!kick_edge && (q.wd_cnt >= WD_SECOND - ONE))
          || (undervoltage_sense_in && !q.uv_q))
      begin
         d.rst_cnt = RST_LEN;
      end
      else if (q.rst_cnt != '0)
      begin
         d.rst_cnt = q.rst_cnt - ONE;
      end
      d.rst_n = d.rst_cnt == '0;

      // Regulator
      case (q.reg_st)
         cms_pkg::CMS_REG_OFF:
         begin
            if (!regulator_wake_n_in && shutdown_n_in)
            begin
               d.reg_st = cms_pkg::CMS_REG_ON;
            end
         end
         cms_pkg::CMS_REG_ON:
         begin
            if (!shutdown_n_in)
            begin
               d.reg_st = cms_pkg::CMS_REG_OFF;
            end
            else if (regulator_wake_n_in && !regulator_hold_n_in)
            begin
               d.reg_st = cms_pkg::CMS_REG_OFF;
            end
         end
         default:
         begin
            d.reg_st = cms_pkg::CMS_REG_OFF;
         end
      endcase

      if (q.reg_st != cms_pkg::CMS_REG_ON)
      begin
         d.rail_cnt   = '0;
         d.rail_ready = 1'b0;
      end
      else if (q.rail_cnt < RAIL_LEN - ONE)
      begin
         d.rail_cnt = q.rail_cnt + ONE;
      end
      else
      begin
         d.rail_ready = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         q          <= '0;
         q.cmd      <= cms_pkg::cms_cmd_s'(cms_pkg::CMD_RESET);
         q.mode     <= cms_pkg::CMS_MODE_NORMAL;
         q.reg_st   <= cms_pkg::CMS_REG_OFF;
         q.hysteresis_set_pin_adj <= 1'b1;
         q.pt0      <= 1'b1;
         q.pt1      <= 1'b1;
         q.pt_oe_n  <= 1'b1;
         q.alert_n  <= 1'b1;
         q.rst_n    <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign status_word_out          = {q.contact_state_bits, cms_pkg::STATUS_LOW_ZERO, 1'b0};
   assign contact_state_bits_out   = q.contact_state_bits;
   assign command_word_out         = q.cmd;
   assign alert_n_out              = q.alert_n;
   assign alert_oe_n_out           = q.alert_n;
   assign reset_n_out              = q.rst_n;
   assign reset_oe_n_out           = q.rst_n;
   // One-hot state: bit 1 is the on state
   assign regulator_on_out         = q.reg_st[1];
   assign rail_ready_out           = q.rail_ready;
   assign passthrough_out0         = q.pt0;
   assign passthrough_out1         = q.pt1;
   assign passthrough_oe_n_out     = q.pt_oe_n;
   assign sense_enable_out         = q.sense_en;
   assign battery_polarity_out     = q.bat_pol;
   assign hysteresis_adjust_en_out = q.hysteresis_set_pin_adj;
   assign mode_out                 = q.mode;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   kick_restart_a: assert property ((watchdog_kick_in != q.kick_q) |=> q.wd_cnt == '0)
      else $error("watchdog not restarted by kick edge");
   first_timeout_a: assert property ((q.wd_cnt == WD_FIRST - ONE)
      && (watchdog_kick_in == q.kick_q) |=> !alert_n_out)
      else $error("alert missing at first timeout");
   second_timeout_a: assert property ((q.wd_cnt == WD_SECOND - ONE)
      && (watchdog_kick_in == q.kick_q) |=> !reset_n_out && alert_n_out
      && q.rst_cnt == RST_LEN)
      else $error("reset pulse or alert release wrong at second timeout");
   uv_reset_a: assert property ($rose(undervoltage_sense_in) && !srst_in |=> !reset_n_out
      && q.rst_cnt == RST_LEN)
      else $error("undervoltage reset missing");
   shut_reg_a: assert property (!shutdown_n_in |=> ##1 !regulator_on_out
      && sense_enable_out == 8'h00)
      else $error("shutdown did not stop regulator or sensing");
   wake_reg_a: assert property (!regulator_wake_n_in && shutdown_n_in |=> regulator_on_out)
      else $error("wake did not turn regulator on");
   hold_off_a: assert property (regulator_on_out && regulator_wake_n_in
      && !regulator_hold_n_in |=> !regulator_on_out)
      else $error("regulator not turned off by hold low");
   rail_wait_a: assert property ($rose(regulator_on_out) |-> !rail_ready_out)
      else $error("rail ready before startup interval");
   cs_clear_a: assert property (spi_cs_fall_in && q.alert && !(|changed)
      && (q.wd_cnt != WD_FIRST - ONE) |=> alert_n_out)
      else $error("chip-select fall did not clear alert");
   pass_path_a: assert property (pt_act && !srst_in
      |=> passthrough_out0 == $past(contact_inputs_in[0])
      && !passthrough_oe_n_out && !sense_enable_out[0])
      else $error("pass-through output wrong");
   fixed_hysteresis_set_pin_a: assert property (q.cmd.scan_config_field == cms_pkg::SCAN_FIXED_HYSTERESIS_SET_PIN
      |=> !hysteresis_adjust_en_out)
      else $error("adjustable hysteresis not disabled");

endmodule // cms_supervisor

`default_nettype wire

// *** tb/cms_mcu_model.sv ***
/*
 * Microcontroller partner: feeds the watchdog, writes whole command words,
 * answers an alert with hold high, a status read, then hold low.
 * Assumes the supervisor's strobe ports stand in for the SPI shifter.
 */
`timescale 1ns/100ps
`default_nettype none

module cms_mcu_model (
   input  wire logic        sys_clk_in,    // System clock
   input  wire logic        kick_en_in,    // Keep toggling the kick
   input  wire logic        serve_en_in,   // Answer alerts
   input  wire logic        wr_req_in,     // Start a command write
   input  wire logic [15:0] wr_word_in,    // Word for that write
   input  wire logic        wake_n_in,     // Shared alert/wake line
   output logic             kick_out,      // Watchdog kick
   output logic             hold_n_out,    // Regulator hold
   output logic             cs_fall_out,   // Select fall strobe
   output logic             cmd_load_out,  // Select rise strobe
   output logic [15:0]      cmd_word_out   // Shifted word
);
   logic [3:0]  kick_cnt = 4'h0;
   logic [4:0]  frame_cnt = 5'h0;
   logic [1:0]  phase = 2'h0;
   logic [15:0] last_word = 16'h0000;

   initial
   begin
      kick_out = 1'b0;
      hold_n_out = 1'b0;
      cs_fall_out = 1'b0;
      cmd_load_out = 1'b0;
      cmd_word_out = 16'h0000;
   end

   always @(posedge sys_clk_in)
   begin
      cs_fall_out  <= 1'b0;
      cmd_load_out <= 1'b0;
      // Word is only valid with the load strobe
      cmd_word_out <= ~cmd_word_out;
      kick_cnt     <= kick_cnt + 4'h1;
      if (kick_en_in && kick_cnt == 4'h0)
         kick_out <= ~kick_out;
      if (frame_cnt != 5'h0)
      begin
         frame_cnt <= frame_cnt + 5'h1;
         if (frame_cnt == 5'h10)
         begin
            cmd_load_out <= 1'b1;
            cmd_word_out <= last_word;
            frame_cnt    <= 5'h0;
         end
      end
      else if (wr_req_in)
      begin
         last_word   <= wr_word_in;
         frame_cnt   <= 5'h1;
         cs_fall_out <= 1'b1;
      end
      else if (phase == 2'h1)
      begin
         frame_cnt   <= 5'h1;
         cs_fall_out <= 1'b1;
         phase       <= 2'h2;
      end
      if (phase == 2'h0 && serve_en_in && !wake_n_in)
      begin
         hold_n_out <= 1'b1;
         phase      <= 2'h1;
      end
      if (phase == 2'h2 && frame_cnt == 5'h0 && wake_n_in)
      begin
         hold_n_out <= 1'b0;
         phase      <= 2'h0;
      end
   end
endmodule // cms_mcu_model

`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the contact monitor supervisor.
 * Assumes the microcontroller model on the far side and short timing counts.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   localparam int RST_C = 8;
   localparam int RAIL_C = 5;
   localparam int SPER_C = 20;
   localparam int SON_C = 4;

   logic        clk, srst, shut_n, kick_en, serve_en, wr_req, uv, wake_drv_n;
   logic        kick, hold_n, cs_fall, cmd_load, alert_n, alert_oe_n, rst_n;
   logic        rst_oe_n, reg_on, rail_rdy, pt0, pt1, pt_oe_n, hysteresis_set_pin_en, kick_d;
   logic        pt, al;
   logic [15:0] wr_word, cmd_word, status, cmd_out, w;
   logic [7:0]  contacts, cstate, sense, exp_st, nc;
   logic [3:0]  bpol;
   logic [2:0]  mode;
   int          n_mismatch, n_tests, cyc, last_kick, k, d;
   wire         wake_n;

   assign wake_n = (alert_oe_n ? 1'b1 : alert_n) & wake_drv_n;

   cms_supervisor #(.RST_PULSE_CYCLES(RST_C), .RAIL_START_CYCLES(RAIL_C),
      .SCAN_PERIOD_CYCLES(SPER_C), .SCAN_ON_CYCLES(SON_C)) dut_u (
      .sys_clk_in(clk), .srst_in(srst), .shutdown_n_in(shut_n),
      .contact_inputs_in(contacts), .watchdog_kick_in(kick),
      .regulator_wake_n_in(wake_n), .regulator_hold_n_in(hold_n),
      .undervoltage_sense_in(uv), .spi_cs_fall_in(cs_fall), .cmd_load_in(cmd_load),
      .cmd_word_in(cmd_word), .status_word_out(status), .contact_state_bits_out(cstate),
      .command_word_out(cmd_out), .alert_n_out(alert_n), .alert_oe_n_out(alert_oe_n),
      .reset_n_out(rst_n), .reset_oe_n_out(rst_oe_n), .regulator_on_out(reg_on),
      .rail_ready_out(rail_rdy), .passthrough_out0(pt0), .passthrough_out1(pt1),
      .passthrough_oe_n_out(pt_oe_n), .sense_enable_out(sense),
      .battery_polarity_out(bpol), .hysteresis_adjust_en_out(hysteresis_set_pin_en), .mode_out(mode));

   cms_mcu_model mcu_u (.sys_clk_in(clk), .kick_en_in(kick_en), .serve_en_in(serve_en),
      .wr_req_in(wr_req), .wr_word_in(wr_word), .wake_n_in(wake_n), .kick_out(kick),
      .hold_n_out(hold_n), .cs_fall_out(cs_fall), .cmd_load_out(cmd_load),
      .cmd_word_out(cmd_word));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic write_cmd(input logic [15:0] wd);
      wr_req <= 1'b1;
      wr_word <= wd;
      tick(1);
      wr_req <= 1'b0;
      tick(24);
   endtask

   function automatic logic alert_exp(logic [7:0] o, logic [7:0] n, logic [7:0] m, logic p);
      return |((o ^ n) & ~m & (p ? 8'hFC : 8'hFF));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      kick_d <= kick;
      if (kick !== kick_d)
         last_kick <= cyc;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude;
   end

   initial
   begin
      {srst, shut_n, kick_en, serve_en, wr_req, uv, wake_drv_n} = 7'b1110001;
      {wr_word, contacts, exp_st, kick_d} = '0;
      {n_mismatch, n_tests, cyc, last_kick} = '0;
      void'($urandom(32'h157D));
      tick(10);
      srst <= 1'b0;
      tick(4);
      check(cmd_out, 16'h0000);
      check(mode, 3'b001);
      check(bpol, 4'h0);
      check({reg_on, rst_n, alert_n, pt_oe_n}, 4'b0110);
      check(sense, 8'hFC);
      for (int i = 0; i < 12; i++)
      begin
         w = {5'h00, 3'($urandom), 8'($urandom)};
         if (i == 0)
            w = 16'h0400;
         write_cmd(w);
         pt = !w[10];
         check(cmd_out, w);
         check(bpol, {w[9], w[9], w[8], w[8]});
         check(sense, pt ? 8'hFC : 8'hFF);
         check(pt_oe_n, !pt);
         al = alert_exp(exp_st, contacts, w[7:0], pt);
         exp_st = pt ? {contacts[7:2], exp_st[1:0]} : contacts;
         nc = (i == 3) ? (contacts ^ w[7:0]) : 8'($urandom);
         al = al | alert_exp(exp_st, nc, w[7:0], pt);
         contacts <= nc;
         exp_st = pt ? {nc[7:2], exp_st[1:0]} : nc;
         tick(5);
         check(cstate, exp_st);
         check(status, {exp_st, 8'h00});
         check({alert_n, reg_on}, {!al, al});
         if (pt)
            check({pt1, pt0}, nc[1:0]);
         serve_en <= 1'b1;
         tick(40);
         serve_en <= 1'b0;
         check({alert_n, hold_n, reg_on, rail_rdy}, 4'b1000);
      end
      wake_drv_n <= 1'b0;
      for (k = 0; k < 20 && reg_on !== 1'b1; k++)
         tick(1);
      for (k = 0; k < 50 && rail_rdy !== 1'b1; k++)
         tick(1);
      check(16'(k >= RAIL_C && k <= RAIL_C + 2), 16'h1);
      wake_drv_n <= 1'b1;
      tick(4);
      check({reg_on, rail_rdy}, 2'b00);
      for (int f = 7; f >= 0; f--)
      begin
         write_cmd({2'b00, 3'(f), 3'b100, 8'hFF});
         check({mode, hysteresis_set_pin_en, pt_oe_n}, (f == 0) ? 5'b00111 : 5'b01001);
         d = 0;
         for (k = 0; k < SPER_C; k++)
         begin
            d += (sense != 8'h00);
            tick(1);
         end
         check(16'(d), (f == 0) ? 16'(SPER_C) : 16'(SON_C));
      end
      shut_n <= 1'b0;
      wake_drv_n <= 1'b0;
      tick(4);
      check({mode, sense, reg_on}, {3'b100, 8'h00, 1'b0});
      shut_n <= 1'b1;
      wake_drv_n <= 1'b1;
      tick(60);
      check({alert_n, rst_n}, 2'b11);
      kick_en <= 1'b0;
      for (k = 0; k < 200 && alert_n !== 1'b0; k++)
         tick(1);
      d = cyc - last_kick;
      check(16'(d >= 4 * RST_C && d <= 4 * RST_C + 4), 16'h1);
      for (k = 0; k < 200 && rst_n !== 1'b0; k++)
         tick(1);
      d = cyc - last_kick;
      check(16'(d >= 8 * RST_C && d <= 8 * RST_C + 4), 16'h1);
      tick(1);
      check({alert_n, alert_oe_n, rst_oe_n}, 3'b110);
      for (k = 1; k < 50 && rst_n !== 1'b1; k++)
         tick(1);
      check(16'(k), 16'(RST_C));
      kick_en <= 1'b1;
      tick(10);
      uv <= 1'b1;
      for (k = 0; k < 10 && rst_n !== 1'b0; k++)
         tick(1);
      for (k = 0; k < 50 && rst_n !== 1'b1; k++)
         tick(1);
      check(16'(k), 16'(RST_C));
      tick(20);
      check({rst_n, rst_oe_n}, 2'b11);
      uv <= 1'b0;
      tick(5);
      conclude;
   end
endmodule // tb_top

`default_nettype wire
